// File: rtl/smlc_top.v
// Purpose: Operating-mode sequencing, position status and torque-limit selection of a servo drive.
// Assumes: One 200 MHz clock; the drive_ready pin stands for power-up readiness.
// Notes:   Discrete pins are synchronised; numeric settings are static configuration.
`timescale 1ns/1ps
`include "smlc_defines.vh"

module smlc_top #(
  parameter POS_W         = 32,
  parameter SPD_W         = 16,
  parameter TRQ_W         = 16,
  parameter TIME_W        = 24,
  parameter PULSE_GATE_CYC = `SMLC_PULSE_GATE_CYC,
  parameter SHOT_W        = 24
) (
  input  wire              core_clk,
  input  wire              reset,
  input  wire [2:0]        control_mode_setting,
  input  wire              drive_ready,
  input  wire              mode_switch_in,
  input  wire              ext_position_ctrl_in,
  input  wire              ext_pulse_ratio_in,
  input  wire              manual_forward_in,
  input  wire              manual_reverse_in,
  input  wire              accel_time_select_in,
  input  wire [TIME_W-1:0] accel_time_0,
  input  wire [TIME_W-1:0] decel_time_0,
  input  wire [TIME_W-1:0] accel_time_1,
  input  wire [TIME_W-1:0] decel_time_1,
  input  wire              speed_select_bit0,
  input  wire              speed_select_bit1,
  input  wire              speed_select_bit2,
  input  wire              speed_source_analog,
  input  wire [8*SPD_W-1:0] step_speed_table,
  input  wire [SPD_W-1:0]  analog_speed_command,
  input  wire [SPD_W-1:0]  torque_speed_limit,
  input  wire              torque_mode_speed_limit_source,
  input  wire [SPD_W-1:0]  feedback_speed,
  input  wire [SPD_W-1:0]  zero_speed_threshold,
  input  wire              pulse_a_in,
  input  wire              pulse_b_in,
  input  wire              pulse_quadrature,
  input  wire [1:0]        gear_select_in,
  input  wire [4*POS_W-1:0] gear_numerator_table,
  input  wire [POS_W-1:0]  command_position,
  input  wire [POS_W-1:0]  feedback_position,
  input  wire [POS_W-1:0]  zero_deviation_band,
  input  wire              in_position_output_form,
  input  wire [SHOT_W-1:0] in_position_shot_cycles,
  input  wire              deviation_clear_in,
  input  wire              deviation_clear_input_form,
  input  wire              homing_command_in,
  input  wire              forced_stop_in,
  input  wire              interrupt_enable_in,
  input  wire              interrupt_in,
  input  wire [POS_W-1:0]  interrupt_travel_amount,
  input  wire              torque_limit_sel0_in,
  input  wire              torque_limit_sel1_in,
  input  wire [TRQ_W-1:0]  analog_torque_command,
  input  wire [TRQ_W-1:0]  forward_torque_limit,
  input  wire [TRQ_W-1:0]  reverse_torque_limit,
  input  wire [TRQ_W-1:0]  alternate_torque_limit,
  input  wire [TRQ_W-1:0]  third_torque_limit,
  output reg  [1:0]        active_mode_q,
  output reg  [POS_W-1:0]  pulse_count_q,
  output reg               pulse_enable_q,
  output reg  [POS_W-1:0]  gear_numerator_q,
  output reg               run_active_q,
  output reg               run_reverse_q,
  output reg  [TIME_W-1:0] accel_time_q,
  output reg  [TIME_W-1:0] decel_time_q,
  output reg  [SPD_W-1:0]  target_speed_q,
  output reg  [SPD_W-1:0]  speed_limit_q,
  output reg  [TRQ_W-1:0]  torque_command_q,
  output reg               zero_speed_q,
  output reg  [POS_W-1:0]  deviation_q,
  output reg               zero_deviation_q,
  output reg               in_position_out,
  output reg               deviation_clear_q,
  output reg  [POS_W-1:0]  clear_position_q,
  output reg               homing_start_q,
  output reg               homing_active_q,
  output reg               interrupt_move_q,
  output reg  [POS_W-1:0]  interrupt_move_amount_q,
  output reg  [TRQ_W-1:0]  fwd_torque_limit_q,
  output reg  [TRQ_W-1:0]  rev_torque_limit_q
);

  // --------------------------------------------------------------------------
  // Input synchronisation
  // --------------------------------------------------------------------------
  localparam NSYNC = 21;
  wire [NSYNC-1:0] pin_raw;
  wire [NSYNC-1:0] pin_s;

  assign pin_raw = {drive_ready, mode_switch_in, ext_position_ctrl_in, ext_pulse_ratio_in,
                    manual_forward_in, manual_reverse_in, accel_time_select_in,
                    speed_select_bit0, speed_select_bit1, speed_select_bit2,
                    pulse_a_in, pulse_b_in, gear_select_in, deviation_clear_in,
                    homing_command_in, forced_stop_in, interrupt_enable_in, interrupt_in,
                    torque_limit_sel0_in, torque_limit_sel1_in};

  smlc_sync #(
    .W (NSYNC)
  ) u_sync (
    .core_clk (core_clk),
    .reset    (reset),
    .async_in (pin_raw),
    .sync_out (pin_s)
  );

  wire       rdy_s   = pin_s[20];
  wire       msw_s   = pin_s[19];
  wire       epc_s   = pin_s[18];
  wire       epr_s   = pin_s[17];
  wire       fwd_s   = pin_s[16];
  wire       rev_s   = pin_s[15];
  wire       acc_s   = pin_s[14];
  wire [2:0] xsel_s  = {pin_s[11], pin_s[12], pin_s[13]};
  wire       pa_s    = pin_s[10];
  wire       pb_s    = pin_s[9];
  wire [1:0] gsel_s  = pin_s[8:7];
  wire       dclr_s  = pin_s[6];
  wire       org_s   = pin_s[5];
  wire       emg_s   = pin_s[4];
  wire       ien_s   = pin_s[3];
  wire       iin_s   = pin_s[2];
  wire       tl0_s   = pin_s[1];
  wire       tl1_s   = pin_s[0];

  reg pa_q;
  reg pb_q;
  reg dclr_q;
  reg org_q;
  reg iin_q;
  reg ien_q;
  reg irq_armed_q;
  reg [SHOT_W-1:0] shot_cnt_q;
  reg [31:0] gate_cnt_q;

  // --------------------------------------------------------------------------
  // Mode selection
  // --------------------------------------------------------------------------
  reg [1:0] req_mode;

  always @* begin
    case (control_mode_setting)
      `SMLC_SET_POS:     req_mode = `SMLC_MODE_POS;
      `SMLC_SET_SPD:     req_mode = `SMLC_MODE_SPD;
      `SMLC_SET_TRQ:     req_mode = `SMLC_MODE_TRQ;
      `SMLC_SET_POS_SPD: req_mode = msw_s ? `SMLC_MODE_SPD : `SMLC_MODE_POS;
      `SMLC_SET_POS_TRQ: req_mode = msw_s ? `SMLC_MODE_TRQ : `SMLC_MODE_POS;
      `SMLC_SET_SPD_TRQ: req_mode = msw_s ? `SMLC_MODE_TRQ : `SMLC_MODE_SPD;
      `SMLC_SET_EXT:     req_mode = epc_s ? `SMLC_MODE_POS : (msw_s ? `SMLC_MODE_TRQ : `SMLC_MODE_SPD);
      default:           req_mode = `SMLC_MODE_POS;
    endcase
  end

  always @(posedge core_clk) begin
    if (reset) begin
      active_mode_q <= `SMLC_MODE_IDLE;
    end else if (!rdy_s) begin
      active_mode_q <= `SMLC_MODE_IDLE;
    end else if (control_mode_setting == `SMLC_SET_EXT) begin
      if (zero_speed_q || active_mode_q == `SMLC_MODE_IDLE) begin
        active_mode_q <= req_mode;
      end
    end else begin
      active_mode_q <= req_mode;
    end
  end

  // --------------------------------------------------------------------------
  // Speed and torque commands
  // --------------------------------------------------------------------------
  wire [SPD_W-1:0] step_speed = step_speed_table[xsel_s*SPD_W +: SPD_W];
  wire [SPD_W-1:0] sel_speed  = speed_source_analog ? analog_speed_command : step_speed;
  wire             run_req    = fwd_s | rev_s;

  always @(posedge core_clk) begin
    if (reset) begin
      run_active_q     <= 1'b0;
      run_reverse_q    <= 1'b0;
      accel_time_q     <= {TIME_W{1'b0}};
      decel_time_q     <= {TIME_W{1'b0}};
      target_speed_q   <= {SPD_W{1'b0}};
      speed_limit_q    <= {SPD_W{1'b0}};
      torque_command_q <= {TRQ_W{1'b0}};
      zero_speed_q     <= 1'b1;
    end else begin
      run_active_q  <= run_req && active_mode_q != `SMLC_MODE_IDLE;
      run_reverse_q <= rev_s & ~fwd_s;
      accel_time_q  <= acc_s ? accel_time_1 : accel_time_0;
      decel_time_q  <= acc_s ? decel_time_1 : decel_time_0;
      target_speed_q <= (active_mode_q == `SMLC_MODE_SPD && run_req && !emg_s) ? sel_speed
                                                                               : {SPD_W{1'b0}};
      speed_limit_q <= torque_mode_speed_limit_source ? sel_speed : torque_speed_limit;
      torque_command_q <= (active_mode_q == `SMLC_MODE_TRQ && run_req && !emg_s) ? analog_torque_command
                                                                                 : {TRQ_W{1'b0}};
      zero_speed_q <= feedback_speed < zero_speed_threshold;
    end
  end

  // --------------------------------------------------------------------------
  // Command pulse input
  // --------------------------------------------------------------------------
  wire pa_edge  = pa_s ^ pa_q;
  wire pb_edge  = pb_s ^ pb_q;
  wire quad_dir = pa_s ^ pb_q;
  wire pulse_ok = control_mode_setting != `SMLC_SET_EXT || pulse_enable_q;
  wire gate_req = epc_s & epr_s;

  always @(posedge core_clk) begin
    if (reset) begin
      pa_q          <= 1'b0;
      pb_q          <= 1'b0;
      pulse_count_q <= {POS_W{1'b0}};
      pulse_enable_q <= 1'b0;
      gate_cnt_q    <= 32'h0;
      gear_numerator_q <= {POS_W{1'b0}};
    end else begin
      pa_q <= pa_s;
      pb_q <= pb_s;
      if (gate_req == pulse_enable_q) begin
        gate_cnt_q <= 32'h0;
      end else if (gate_cnt_q >= PULSE_GATE_CYC - 1) begin
        gate_cnt_q     <= 32'h0;
        pulse_enable_q <= gate_req;
      end else begin
        gate_cnt_q <= gate_cnt_q + 32'h1;
      end
      if (pulse_ok && active_mode_q == `SMLC_MODE_POS) begin
        if (pulse_quadrature) begin
          if (pa_edge | pb_edge) begin
            pulse_count_q <= quad_dir ? pulse_count_q - {{(POS_W-1){1'b0}}, 1'b1}
                                      : pulse_count_q + {{(POS_W-1){1'b0}}, 1'b1};
          end
        end else if (pa_s && !pa_q) begin
          pulse_count_q <= pb_s ? pulse_count_q - {{(POS_W-1){1'b0}}, 1'b1}
                                : pulse_count_q + {{(POS_W-1){1'b0}}, 1'b1};
        end
      end
      gear_numerator_q <= gear_numerator_table[gsel_s*POS_W +: POS_W];
    end
  end

  // --------------------------------------------------------------------------
  // Deviation, in-position and clear
  // --------------------------------------------------------------------------
  wire [POS_W-1:0] dev_raw = command_position - feedback_position;
  wire [POS_W-1:0] dev_abs = dev_raw[POS_W-1] ? (~dev_raw + {{(POS_W-1){1'b0}}, 1'b1}) : dev_raw;
  wire             zdev    = dev_abs <= zero_deviation_band;
  wire             dclr_act = deviation_clear_input_form ? (dclr_s & ~dclr_q) : dclr_s;

  always @(posedge core_clk) begin
    if (reset) begin
      dclr_q            <= 1'b0;
      deviation_q       <= {POS_W{1'b0}};
      zero_deviation_q  <= 1'b0;
      in_position_out   <= 1'b0;
      shot_cnt_q        <= {SHOT_W{1'b0}};
      deviation_clear_q <= 1'b0;
      clear_position_q  <= {POS_W{1'b0}};
    end else begin
      dclr_q <= dclr_s;
      deviation_clear_q <= dclr_act;
      clear_position_q  <= feedback_position;
      deviation_q      <= dclr_act ? {POS_W{1'b0}} : dev_raw;
      zero_deviation_q <= dclr_act | zdev;
      if (in_position_output_form == 1'b0) begin
        in_position_out <= zero_deviation_q;
        shot_cnt_q      <= {SHOT_W{1'b0}};
      end else if (!zero_deviation_q) begin
        in_position_out <= 1'b0;
        shot_cnt_q      <= {SHOT_W{1'b0}};
      end else if (shot_cnt_q == {SHOT_W{1'b0}} && !in_position_out) begin
        in_position_out <= (in_position_shot_cycles != {SHOT_W{1'b0}});
        shot_cnt_q      <= in_position_shot_cycles;
      end else if (shot_cnt_q > {{(SHOT_W-1){1'b0}}, 1'b1}) begin
        shot_cnt_q <= shot_cnt_q - {{(SHOT_W-1){1'b0}}, 1'b1};
      end else if (shot_cnt_q != {SHOT_W{1'b0}}) begin
        shot_cnt_q      <= {{(SHOT_W-1){1'b0}}, 1'b1};
        in_position_out <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Homing and interrupt positioning
  // --------------------------------------------------------------------------
  always @(posedge core_clk) begin
    if (reset) begin
      org_q                   <= 1'b0;
      iin_q                   <= 1'b0;
      ien_q                   <= 1'b0;
      irq_armed_q             <= 1'b0;
      homing_start_q          <= 1'b0;
      homing_active_q         <= 1'b0;
      interrupt_move_q        <= 1'b0;
      interrupt_move_amount_q <= {POS_W{1'b0}};
    end else begin
      org_q <= org_s;
      iin_q <= iin_s;
      ien_q <= ien_s;
      homing_start_q <= org_s && !org_q && in_position_out && !emg_s;
      if (emg_s) begin
        homing_active_q <= 1'b0;
      end else if (org_s && !org_q && in_position_out) begin
        homing_active_q <= 1'b1;
      end
      interrupt_move_q <= 1'b0;
      if (!ien_s) begin
        irq_armed_q <= 1'b0;
      end else if (!ien_q) begin
        irq_armed_q <= 1'b1;
      end else if (irq_armed_q && iin_s && !iin_q && run_active_q) begin
        irq_armed_q             <= 1'b0;
        interrupt_move_q        <= 1'b1;
        interrupt_move_amount_q <= interrupt_travel_amount;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Torque limit selection
  // --------------------------------------------------------------------------
  reg [TRQ_W-1:0] fwd_lim;
  reg [TRQ_W-1:0] rev_lim;
  wire [TRQ_W-1:0] fwd_alt = forward_torque_limit < alternate_torque_limit ? forward_torque_limit
                                                                           : alternate_torque_limit;
  wire [TRQ_W-1:0] rev_alt = reverse_torque_limit < alternate_torque_limit ? reverse_torque_limit
                                                                           : alternate_torque_limit;
  wire [TRQ_W-1:0] fwd_an  = analog_torque_command < forward_torque_limit ? analog_torque_command
                                                                          : forward_torque_limit;
  wire [TRQ_W-1:0] rev_an  = analog_torque_command < reverse_torque_limit ? analog_torque_command
                                                                          : reverse_torque_limit;
  wire [TRQ_W-1:0] an_alt  = analog_torque_command < alternate_torque_limit ? analog_torque_command
                                                                            : alternate_torque_limit;

  always @* begin
    fwd_lim = forward_torque_limit;
    rev_lim = reverse_torque_limit;
    if (emg_s) begin
      fwd_lim = third_torque_limit;
      rev_lim = third_torque_limit;
    end else if (active_mode_q != `SMLC_MODE_TRQ) begin
      case ({tl1_s, tl0_s})
        2'h1:    begin fwd_lim = fwd_an; rev_lim = rev_an; end
        2'h2:    begin fwd_lim = fwd_alt; rev_lim = rev_alt; end
        2'h3:    begin fwd_lim = an_alt; rev_lim = an_alt; end
        default: begin fwd_lim = forward_torque_limit; rev_lim = reverse_torque_limit; end
      endcase
    end
  end

  always @(posedge core_clk) begin
    if (reset) begin
      fwd_torque_limit_q <= {TRQ_W{1'b0}};
      rev_torque_limit_q <= {TRQ_W{1'b0}};
    end else begin
      fwd_torque_limit_q <= fwd_lim;
      rev_torque_limit_q <= rev_lim;
    end
  end

endmodule

// File: rtl/smlc_defines.vh
// Purpose: Constants for the servo mode and limit control block.
// Assumes: 200 MHz core clock, 5 ns period.
// Notes:   Included by the top module, the properties file and the bench top; the synchroniser and the host model do not include it.
`ifndef SMLC_DEFINES_VH
`define SMLC_DEFINES_VH

// ----------------------------------------------------------------------------
// Control mode settings
// ----------------------------------------------------------------------------
`define SMLC_SET_POS        3'h0
`define SMLC_SET_SPD        3'h1
`define SMLC_SET_TRQ        3'h2
`define SMLC_SET_POS_SPD    3'h3
`define SMLC_SET_POS_TRQ    3'h4
`define SMLC_SET_SPD_TRQ    3'h5
`define SMLC_SET_EXT        3'h6

// ----------------------------------------------------------------------------
// Active control modes
// ----------------------------------------------------------------------------
`define SMLC_MODE_IDLE      2'h0
`define SMLC_MODE_POS       2'h1
`define SMLC_MODE_SPD       2'h2
`define SMLC_MODE_TRQ       2'h3

// ----------------------------------------------------------------------------
// Extended-mode request encoding
// ----------------------------------------------------------------------------
`define SMLC_EXT_REQ_W      2

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define SMLC_CLK_MHZ        200
`define SMLC_PULSE_GATE_US  2000
`define SMLC_PULSE_GATE_CYC (`SMLC_PULSE_GATE_US * `SMLC_CLK_MHZ)

// ----------------------------------------------------------------------------
// Quadrature multiplier
// ----------------------------------------------------------------------------
`define SMLC_QUAD_COUNTS    4

`endif

// File: rtl/smlc_sync.v
// Purpose: Two-flop synchroniser for a bundle of asynchronous levels.
// Assumes: Inputs come from pins outside the core clock domain.
// Notes:   The first stage is read only by the second stage.
`timescale 1ns/1ps

module smlc_sync #(
  parameter W = 1
) (
  input  wire         core_clk,
  input  wire         reset,
  input  wire [W-1:0] async_in,
  output wire [W-1:0] sync_out
);

  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;

  always @(posedge core_clk) begin
    if (reset) begin
      meta_q <= {W{1'b0}};
      sync_q <= {W{1'b0}};
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;

endmodule

// File: bench/smlc_top_properties.sv
// Purpose: Port-level temporal checks for the servo mode and limit block.
// Assumes: One clock domain; pins reach outputs three edges after a change.
// Notes:   Attached to the top module by the bind at the foot of this file.
`timescale 1ns/1ps
`include "smlc_defines.vh"

module smlc_top_properties #(
  parameter POS_W = 32,
  parameter SPD_W = 16,
  parameter TRQ_W = 16
) (
  input wire logic             core_clk,
  input wire logic             reset,
  input wire logic [2:0]       control_mode_setting,
  input wire logic             drive_ready,
  input wire logic             mode_switch_in,
  input wire logic [SPD_W-1:0] feedback_speed,
  input wire logic [SPD_W-1:0] zero_speed_threshold,
  input wire logic             forced_stop_in,
  input wire logic [TRQ_W-1:0] third_torque_limit,
  input wire logic [POS_W-1:0] interrupt_travel_amount,
  input wire logic [1:0]       active_mode_q,
  input wire logic             zero_speed_q,
  input wire logic             zero_deviation_q,
  input wire logic             in_position_out,
  input wire logic             homing_start_q,
  input wire logic             interrupt_move_q,
  input wire logic [POS_W-1:0] interrupt_move_amount_q,
  input wire logic [TRQ_W-1:0] fwd_torque_limit_q,
  input wire logic [TRQ_W-1:0] rev_torque_limit_q
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  AST_RESET_STATE: assert property ($fell(reset) |-> zero_speed_q && active_mode_q == `SMLC_MODE_IDLE)
    else $error("outputs not at reset state");
  AST_NOT_READY_IDLE: assert property ((!drive_ready)[*5] |-> active_mode_q == `SMLC_MODE_IDLE)
    else $error("mode active without drive ready");
  AST_MODE_SWITCH: assert property ((drive_ready && mode_switch_in && control_mode_setting == 3'h3)[*5]
    |-> active_mode_q == `SMLC_MODE_SPD)
    else $error("mode switch did not select speed");
  AST_ZERO_SPEED: assert property (($stable(feedback_speed) && $stable(zero_speed_threshold))[*4]
    |-> zero_speed_q == (feedback_speed < zero_speed_threshold))
    else $error("zero speed flag wrong");
  AST_INPOS_RISE: assert property ($rose(zero_deviation_q) |-> ##[0:2] in_position_out)
    else $error("in position did not follow zero deviation");
  AST_INPOS_FALL: assert property ($fell(zero_deviation_q) |-> ##[0:2] !in_position_out)
    else $error("in position outlived zero deviation");
  AST_HOMING_PULSE: assert property (homing_start_q |=> !homing_start_q)
    else $error("homing start longer than one cycle");
  AST_FSTOP_LIMIT: assert property (forced_stop_in[*5]
    |-> fwd_torque_limit_q == third_torque_limit && rev_torque_limit_q == third_torque_limit)
    else $error("forced stop limit not applied");
  AST_INTR_AMOUNT: assert property (interrupt_move_q
    |-> interrupt_move_amount_q == interrupt_travel_amount ##1 !interrupt_move_q)
    else $error("interrupt move amount or width wrong");
  COV_HOMING: cover property (homing_start_q);
  COV_INTR: cover property (interrupt_move_q);
  COV_INPOS: cover property ($rose(in_position_out));
endmodule

bind smlc_top smlc_top_properties #(.POS_W(POS_W), .SPD_W(SPD_W), .TRQ_W(TRQ_W)) smlc_top_properties_inst (
  .core_clk, .reset, .control_mode_setting, .drive_ready, .mode_switch_in, .feedback_speed, .zero_speed_threshold,
  .forced_stop_in, .third_torque_limit, .interrupt_travel_amount, .active_mode_q, .zero_speed_q, .zero_deviation_q,
  .in_position_out, .homing_start_q, .interrupt_move_q, .interrupt_move_amount_q, .fwd_torque_limit_q,
  .rev_torque_limit_q);

// File: bench/smlc_host_model.sv
// Purpose: Host pulse generator driving the command pulse pins.
// Assumes: Each phase is held four cycles so the two-flop sync sees it.
// Notes:   Non-quadrature pulses count up, the direction line stays low.
`timescale 1ns/1ps

module smlc_host_model (
  input  wire logic core_clk,
  output logic      pulse_a,
  output logic      pulse_b
);
  initial begin
    pulse_a = 1'b0;
    pulse_b = 1'b0;
  end

  task automatic step(input logic a, input logic b);
    @(posedge core_clk);
    pulse_a <= a;
    pulse_b <= b;
    repeat (3) @(posedge core_clk);
  endtask

  task automatic send(input int n, input logic quad);
    for (int i = 0; i < n; i++) begin
      step(!quad, quad);
      if (quad) begin
        step(1'b1, 1'b1);
        step(1'b1, 1'b0);
      end
      step(1'b0, 1'b0);
    end
  endtask
endmodule

// File: bench/smlc_top_bench.sv
// Purpose: Self-checking bench for the servo mode and limit block.
// Assumes: 200 MHz clock; pulse gate shortened to 8 cycles.
// Notes:   Settings are static while outputs are sampled after several edges.
`timescale 1ns/1ps
`include "smlc_defines.vh"
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin miscompares++; \
  $display("mismatch at %0t: got %0h expected %0h", $time, (a), (e)); end end

module smlc_top_bench;
  logic        core_clk, reset, drive_ready, mode_switch_in, ext_position_ctrl_in, ext_pulse_ratio_in;
  logic        manual_forward_in, manual_reverse_in, accel_time_select_in, speed_select_bit0, speed_select_bit1;
  logic        speed_select_bit2, speed_source_analog, torque_mode_speed_limit_source, pulse_quadrature;
  logic        in_position_output_form, deviation_clear_in, deviation_clear_input_form, homing_command_in;
  logic        forced_stop_in, interrupt_enable_in, interrupt_in, torque_limit_sel0_in, torque_limit_sel1_in;
  logic [2:0]  control_mode_setting;
  logic [1:0]  gear_select_in, active_mode_q;
  logic [23:0] accel_time_0, decel_time_0, accel_time_1, decel_time_1, in_position_shot_cycles;
  logic [23:0] accel_time_q, decel_time_q;
  logic [127:0] step_speed_table, gear_numerator_table;
  logic [15:0] analog_speed_command, torque_speed_limit, feedback_speed, zero_speed_threshold;
  logic [15:0] analog_torque_command, forward_torque_limit, reverse_torque_limit, alternate_torque_limit;
  logic [15:0] third_torque_limit, target_speed_q, speed_limit_q, torque_command_q;
  logic [15:0] fwd_torque_limit_q, rev_torque_limit_q;
  logic [31:0] command_position, feedback_position, zero_deviation_band, interrupt_travel_amount;
  logic [31:0] pulse_count_q, gear_numerator_q, deviation_q, clear_position_q, interrupt_move_amount_q;
  logic        pulse_a_in, pulse_b_in, pulse_enable_q, run_active_q, run_reverse_q, zero_speed_q;
  logic        zero_deviation_q, in_position_out, deviation_clear_q, homing_start_q, homing_active_q, interrupt_move_q;
  int          miscompares, samples_checked, hits, homes, moves;
  logic [1:0]  mexp [12] = '{1, 1, 2, 2, 3, 3, 1, 2, 1, 3, 2, 3};
  logic [31:0] tlim [4] = '{32'h0100_0300, 32'h0100_0250, 32'h0100_0200, 32'h0200_0200};

  smlc_top #(.PULSE_GATE_CYC(8)) smlc_top_inst (.*);
  smlc_host_model smlc_host_model_inst (.core_clk(core_clk), .pulse_a(pulse_a_in), .pulse_b(pulse_b_in));

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task automatic print_verdict;
    if (miscompares == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  always @(posedge core_clk) begin
    if (in_position_out === 1'b1) hits++;
    if (homing_start_q === 1'b1) homes++;
    if (interrupt_move_q === 1'b1) moves++;
  end

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    miscompares++;
    print_verdict();
  end

  initial begin
    {drive_ready, mode_switch_in, ext_position_ctrl_in, ext_pulse_ratio_in, manual_forward_in, manual_reverse_in,
     accel_time_select_in, speed_select_bit0, speed_select_bit1, speed_select_bit2, speed_source_analog,
     torque_mode_speed_limit_source, pulse_quadrature, in_position_output_form, deviation_clear_in,
     deviation_clear_input_form, homing_command_in, forced_stop_in, interrupt_enable_in, interrupt_in,
     torque_limit_sel0_in, torque_limit_sel1_in, control_mode_setting, gear_select_in, accel_time_0, decel_time_0,
     accel_time_1, decel_time_1, step_speed_table, analog_speed_command, torque_speed_limit, feedback_speed,
     command_position, feedback_position} = '0;
    {hits, homes, moves, miscompares, samples_checked} = '0;
    reset = 1'b1;
    zero_speed_threshold = 16'h0010;
    zero_deviation_band = 32'h0000_0010;
    in_position_shot_cycles = 24'h000005;
    interrupt_travel_amount = 32'h0000_0123;
    gear_numerator_table = {32'h0000_0044, 32'h0000_0033, 32'h0000_0022, 32'h0000_0011};
    {forward_torque_limit, reverse_torque_limit} = 32'h0100_0300;
    {alternate_torque_limit, analog_torque_command, third_torque_limit, analog_speed_command} = 64'h0200_0250_0040_0321;
    cyc(4);
    reset <= 1'b0;
    cyc(1);
    `CHK(zero_speed_q, 1'b1)
    drive_ready <= 1'b1;
    pulse_quadrature <= 1'b1;
    cyc(8);
    `CHK(active_mode_q, `SMLC_MODE_POS)
    smlc_host_model_inst.send(3, 1'b1);
    cyc(6);
    `CHK(pulse_count_q, 32'h0000_000C)
    pulse_quadrature <= 1'b0;
    smlc_host_model_inst.send(2, 1'b0);
    cyc(6);
    `CHK(pulse_count_q, 32'h0000_000E)
    for (int i = 0; i < 4; i++) begin
      {torque_limit_sel1_in, torque_limit_sel0_in} <= i[1:0];
      gear_select_in <= i[1:0];
      cyc(6);
      `CHK({fwd_torque_limit_q, rev_torque_limit_q}, tlim[i])
      `CHK(gear_numerator_q, gear_numerator_table[i*32 +: 32])
    end
    in_position_output_form <= 1'b1;
    command_position <= 32'h0000_1000;
    cyc(8);
    hits = 0;
    command_position <= 32'h0000_0000;
    cyc(20);
    `CHK(hits, 5)
    in_position_shot_cycles <= 24'h000032;
    command_position <= 32'h0000_1000;
    cyc(8);
    command_position <= 32'h0000_0000;
    cyc(10);
    `CHK(in_position_out, 1'b1)
    command_position <= 32'h0000_1000;
    cyc(6);
    `CHK(in_position_out, 1'b0)
    in_position_output_form <= 1'b0;
    command_position <= 32'h0000_0000;
    cyc(8);
    `CHK(zero_deviation_q, 1'b1)
    homing_command_in <= 1'b1;
    cyc(8);
    `CHK(homes, 1)
    forced_stop_in <= 1'b1;
    cyc(8);
    `CHK(homing_active_q, 1'b0)
    `CHK({fwd_torque_limit_q, rev_torque_limit_q}, 32'h0040_0040)
    {forced_stop_in, homing_command_in} <= 2'b00;
    for (int i = 0; i < 12; i++) begin
      control_mode_setting <= i / 2;
      mode_switch_in <= i % 2;
      cyc(6);
      `CHK(active_mode_q, mexp[i])
    end
    {control_mode_setting, mode_switch_in, ext_position_ctrl_in, ext_pulse_ratio_in} <= 6'b110_0_11;
    cyc(20);
    `CHK(active_mode_q, `SMLC_MODE_POS)
    `CHK(pulse_enable_q, 1'b1)
    smlc_host_model_inst.send(1, 1'b0);
    cyc(6);
    `CHK(pulse_count_q, 32'h0000_000F)
    feedback_speed <= 16'h0100;
    cyc(6);
    ext_position_ctrl_in <= 1'b0;
    cyc(8);
    `CHK(active_mode_q, `SMLC_MODE_POS)
    feedback_speed <= 16'h0000;
    cyc(8);
    `CHK(active_mode_q, `SMLC_MODE_SPD)
    control_mode_setting <= 3'h1;
    {speed_source_analog, torque_mode_speed_limit_source} <= 2'b11;
    manual_forward_in <= 1'b1;
    cyc(8);
    `CHK(run_active_q, 1'b1)
    `CHK(target_speed_q, 16'h0321)
    `CHK(speed_limit_q, 16'h0321)
    interrupt_enable_in <= 1'b1;
    cyc(6);
    repeat (2) begin
      interrupt_in <= 1'b1;
      cyc(6);
      interrupt_in <= 1'b0;
      cyc(6);
    end
    `CHK(moves, 1)
    manual_forward_in <= 1'b0;
    cyc(8);
    `CHK(run_active_q, 1'b0)
    print_verdict();
  end
endmodule
